// [logic/tcp_header_generator.sv]
// How it works
// - Null option sends the checksum field as zero.
// - No connection option: frames flow without any handshake.
// - Active open: SYN handshake first, traffic only once established.
// - Passive open: traffic waits until a peer opened a connection.
// - Passive open: peer MAC, IP and port come from the incoming SYN.
// - SYN chosen: SYN carries configured sequence (zero under auto increment), next packet plus one plus any counted data.
// - No SYN: first packet carries the configured sequence, or zero under auto increment.
// - Auto increment: sequence counts data bytes from zero.
// - ACK set: acknowledgement field holds next expected peer sequence under open, configured value otherwise.
// - Data offset is the header length in 32-bit words.
// - Reserved bits are sent as zero.
// - Eight flags programmable; under open the connection machine drives SYN and ACK, RST and FIN are zero.
// - Window field sent as configured.
// - 16-bit checksum covers header and data.
// - URG set: urgent pointer field sent, else zero.
`timescale 1ns/10ps
`default_nettype none
`include "tcp_hdr_defines.svh"

module tcp_header_generator
    import tcp_hdr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_active_open,
    input wire logic i_passive_open,
    input wire logic i_auto_inc,
    input wire logic i_zero_csum,
    input wire logic [15:0] i_src_port,
    input wire logic [15:0] i_dst_port,
    input wire logic [31:0] i_seq_cfg,
    input wire logic [31:0] i_ack_cfg,
    input wire logic [7:0] i_flags_cfg,
    input wire logic [15:0] i_window,
    input wire logic [15:0] i_urg_ptr,
    input wire logic [15:0] i_pseudo_sum,
    input wire logic i_frame_req,
    input wire logic [15:0] i_payload_len,
    input wire logic [15:0] i_payload_sum,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_flags,
    input wire logic [31:0] i_rx_seq,
    input wire logic [15:0] i_rx_len,
    input wire logic [47:0] i_rx_mac,
    input wire logic [31:0] i_rx_ip,
    input wire logic [15:0] i_rx_port,
    output logic o_frame_ack,
    output logic o_traffic_ready,
    output logic [4:0] o_conn_state,
    output logic o_hdr_valid,
    output logic [15:0] o_hdr_word,
    output logic o_hdr_last,
    output logic [47:0] o_peer_mac,
    output logic [31:0] o_peer_ip,
    output logic [15:0] o_peer_port
);
    // ************************************************************
    // State
    // ************************************************************
    conn_state_t conn_q, conn_d;
    phase_t ph_q, ph_d;
    logic [15:0] hdr_q [`HDR_WORDS];
    logic [15:0] hdr_d [`HDR_WORDS];
    logic [31:0] seq_q, seq_d, ack_q, ack_d;
    logic [3:0] idx_q, idx_d, oidx_q, oidx_d;
    logic [15:0] psum_q, psum_d, tlen_q, tlen_d;
    logic zc_q, zc_d, first_q, first_d, ctrl_q, ctrl_d;
    logic [7:0] cflg_q, cflg_d;
    logic conn_mode_q, conn_mode_d;
    logic ack_o_q, ack_o_d, rdy_q, rdy_d;
    logic vld_q, vld_d, last_q, last_d;
    logic [15:0] word_q, word_d;
    logic [47:0] pmac_q, pmac_d;
    logic [31:0] pip_q, pip_d;
    logic [15:0] pport_q, pport_d;
    logic take, syn_bit;
    logic [7:0] flg;
    logic [15:0] dport, len, pay;
    logic [31:0] seq_out, ack_out;

    csum_if cs ();

    csum_accum u_csum (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .cs(cs)
    );

    assign o_frame_ack = ack_o_q;
    assign o_traffic_ready = rdy_q;
    assign o_conn_state = conn_q;
    assign o_hdr_valid = vld_q;
    assign o_hdr_word = word_q;
    assign o_hdr_last = last_q;
    assign o_peer_mac = pmac_q;
    assign o_peer_ip = pip_q;
    assign o_peer_port = pport_q;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        conn_d = conn_q;
        ph_d = ph_q;
        hdr_d = hdr_q;
        seq_d = seq_q;
        ack_d = ack_q;
        idx_d = idx_q;
        oidx_d = oidx_q;
        psum_d = psum_q;
        tlen_d = tlen_q;
        zc_d = zc_q;
        first_d = first_q;
        ctrl_d = ctrl_q;
        cflg_d = cflg_q;
        conn_mode_d = conn_mode_q;
        pmac_d = pmac_q;
        pip_d = pip_q;
        pport_d = pport_q;
        ack_o_d = 1'b0;
        vld_d = 1'b0;
        last_d = 1'b0;
        word_d = word_q;
        cs.load = 1'b0;
        cs.add = 1'b0;
        cs.word = 16'h0000;

        // Taking a segment clears the pending control before any new one
        // is queued below, so a control set in the same cycle is not lost
        take = (ph_q == PH_IDLE) && (ctrl_q || (i_frame_req && rdy_q));
        if (take) begin
            ctrl_d = 1'b0;
        end

        // Connection handling
        unique case (conn_q)
            CONN_CLOSED: begin
                if (i_start) begin
                    first_d = 1'b1;
                    ack_d = i_ack_cfg;
                    seq_d = i_auto_inc ? `SEQ_RST : i_seq_cfg;
                    conn_mode_d = i_active_open | i_passive_open;
                    if (i_active_open) begin
                        ctrl_d = 1'b1;
                        cflg_d = 8'h02;
                        conn_d = CONN_SYN_SENT;
                    end else if (i_passive_open) begin
                        conn_d = CONN_LISTEN;
                    end else begin
                        conn_d = CONN_ESTAB;
                    end
                end
            end
            CONN_LISTEN: begin
                if (i_rx_valid && i_rx_flags[`FLG_SYN]) begin
                    pmac_d = i_rx_mac;
                    pip_d = i_rx_ip;
                    pport_d = i_rx_port;
                    ack_d = i_rx_seq + 32'h0000_0001;
                    ctrl_d = 1'b1;
                    cflg_d = 8'h12;
                    conn_d = CONN_SYN_RCVD;
                end
            end
            CONN_SYN_SENT: begin
                if (i_rx_valid && i_rx_flags[`FLG_SYN]
                    && i_rx_flags[`FLG_ACK]) begin
                    ack_d = i_rx_seq + 32'h0000_0001;
                    ctrl_d = 1'b1;
                    cflg_d = 8'h10;
                    conn_d = CONN_ESTAB;
                end
            end
            CONN_SYN_RCVD: begin
                if (i_rx_valid && i_rx_flags[`FLG_ACK]) begin
                    conn_d = CONN_ESTAB;
                end
            end
            CONN_ESTAB: begin
                // Track peer data so the next ACK is correct
                if (i_rx_valid && conn_mode_q) begin
                    ack_d = i_rx_seq + {16'h0000, i_rx_len};
                end
            end
        endcase
        if (i_rx_valid && i_rx_flags[`FLG_RST] && conn_mode_q) begin
            conn_d = CONN_CLOSED;
            ctrl_d = 1'b0;
        end
        rdy_d = (conn_d == CONN_ESTAB) && !ctrl_d;

        // Field selection for a new segment; control beats data
        len = ctrl_q ? 16'h0000 : i_payload_len;
        pay = ctrl_q ? 16'h0000 : i_payload_sum;
        if (conn_mode_q) begin
            flg = i_flags_cfg & 8'he8;
            flg[`FLG_ACK] = ctrl_q ? cflg_q[`FLG_ACK] : 1'b1;
            flg[`FLG_SYN] = ctrl_q & cflg_q[`FLG_SYN];
        end else begin
            flg = i_flags_cfg;
            flg[`FLG_SYN] = i_flags_cfg[`FLG_SYN] & first_q;
        end
        syn_bit = flg[`FLG_SYN];
        dport = (i_passive_open && conn_mode_q) ? pport_q : i_dst_port;
        seq_out = seq_q;
        ack_out = flg[`FLG_ACK] ? ack_q : 32'h0000_0000;

        unique case (ph_q)
            PH_IDLE: begin
                if (take) begin
                    ack_o_d = !ctrl_q;
                    first_d = 1'b0;
                    hdr_d[0] = i_src_port;
                    hdr_d[1] = dport;
                    hdr_d[2] = seq_out[31:16];
                    hdr_d[3] = seq_out[15:0];
                    hdr_d[4] = ack_out[31:16];
                    hdr_d[5] = ack_out[15:0];
                    hdr_d[6] = {`DATA_OFFSET_VAL, `RESERVED_VAL,
                        flg};
                    hdr_d[7] = i_window;
                    hdr_d[8] = 16'h0000;
                    hdr_d[9] = flg[`FLG_URG] ? i_urg_ptr : 16'h0000;
                    // SYN takes one number; data advances only when tracked
                    seq_d = seq_q + {31'h0, syn_bit}
                        + ((i_auto_inc || conn_mode_q)
                        ? {16'h0000, len} : 32'h0000_0000);
                    psum_d = pay;
                    tlen_d = `HDR_BYTES + len;
                    zc_d = i_zero_csum;
                    cs.load = 1'b1;
                    cs.word = i_pseudo_sum;
                    idx_d = 4'h1;
                    ph_d = PH_SUM;
                end
            end
            PH_SUM: begin
                cs.add = 1'b1;
                if (idx_q == 4'h1) begin
                    cs.word = psum_q;
                end else if (idx_q == 4'h2) begin
                    cs.word = tlen_q;
                end else begin
                    cs.word = hdr_q[idx_q - 4'h3];
                end
                idx_d = idx_q + 4'h1;
                if (idx_q == `ADDEND_LAST) begin
                    idx_d = 4'h0;
                    ph_d = PH_EMIT;
                end
            end
            PH_EMIT: begin
                vld_d = 1'b1;
                oidx_d = idx_q;
                word_d = hdr_q[idx_q];
                if (idx_q == `CSUM_WORD_IDX) begin
                    word_d = zc_q ? 16'h0000 : ~cs.sum;
                end
                idx_d = idx_q + 4'h1;
                if (idx_q == `LAST_WORD_IDX) begin
                    last_d = 1'b1;
                    idx_d = 4'h0;
                    ph_d = PH_IDLE;
                end
            end
            default: begin
                ph_d = PH_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            conn_q <= CONN_CLOSED;
            ph_q <= PH_IDLE;
            hdr_q <= '{default: 16'h0000};
            seq_q <= `SEQ_RST;
            ack_q <= `ACK_RST;
            idx_q <= 4'h0;
            oidx_q <= 4'h0;
            psum_q <= 16'h0000;
            tlen_q <= 16'h0000;
            zc_q <= 1'b0;
            first_q <= 1'b0;
            ctrl_q <= 1'b0;
            cflg_q <= 8'h00;
            conn_mode_q <= 1'b0;
            ack_o_q <= 1'b0;
            rdy_q <= 1'b0;
            vld_q <= 1'b0;
            last_q <= 1'b0;
            word_q <= 16'h0000;
            pmac_q <= 48'h0000_0000_0000;
            pip_q <= 32'h0000_0000;
            pport_q <= 16'h0000;
        end else begin
            conn_q <= conn_d;
            ph_q <= ph_d;
            hdr_q <= hdr_d;
            seq_q <= seq_d;
            ack_q <= ack_d;
            idx_q <= idx_d;
            oidx_q <= oidx_d;
            psum_q <= psum_d;
            tlen_q <= tlen_d;
            zc_q <= zc_d;
            first_q <= first_d;
            ctrl_q <= ctrl_d;
            cflg_q <= cflg_d;
            conn_mode_q <= conn_mode_d;
            ack_o_q <= ack_o_d;
            rdy_q <= rdy_d;
            vld_q <= vld_d;
            last_q <= last_d;
            word_q <= word_d;
            pmac_q <= pmac_d;
            pip_q <= pip_d;
            pport_q <= pport_d;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_null_csum_zero: assert property (
        @(posedge i_clk) disable iff (i_rst)
        vld_q && oidx_q == `CSUM_WORD_IDX && zc_q |-> word_q == 16'h0000)
        else $error("checksum not zero under null option");
    a_data_waits_open: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_frame_ack |-> $past(conn_q) == CONN_ESTAB)
        else $error("data frame taken before connection open");
    a_listen_holds: assert property (
        @(posedge i_clk) disable iff (i_rst)
        conn_q == CONN_LISTEN |-> !rdy_q)
        else $error("traffic ready while listening");
    a_peer_latched: assert property (
        @(posedge i_clk) disable iff (i_rst)
        conn_q == CONN_LISTEN && i_rx_valid && i_rx_flags[`FLG_SYN]
        && !i_rx_flags[`FLG_RST] |=> pport_q == $past(i_rx_port))
        else $error("peer port not taken from incoming syn");
    a_offset_field: assert property (
        @(posedge i_clk) disable iff (i_rst)
        vld_q && oidx_q == 4'h6 |-> word_q[15:8] == 8'h50)
        else $error("data offset or reserved bits wrong");
    a_syn_steps_seq: assert property (
        @(posedge i_clk) disable iff (i_rst)
        ph_q == PH_IDLE && take && syn_bit && len == 16'h0000
        |=> seq_q == $past(seq_q) + 32'h0000_0001)
        else $error("sequence did not step after syn");
    a_first_word_port: assert property (
        @(posedge i_clk) disable iff (i_rst)
        vld_q && oidx_q == 4'h0 |-> word_q == hdr_q[0] ##1 vld_q)
        else $error("source port word wrong or frame cut");
    // Word 0 here, words 1 to 8 valid next, word 9 carries last
    a_frame_length: assert property (
        @(posedge i_clk) disable iff (i_rst)
        vld_q && oidx_q == 4'h0 |=> vld_q [*8] ##1 vld_q && last_q)
        else $error("header not ten words long");
    a_urg_clear: assert property (
        @(posedge i_clk) disable iff (i_rst)
        vld_q && oidx_q == `LAST_WORD_IDX && !hdr_q[6][`FLG_URG]
        |-> word_q == 16'h0000)
        else $error("urgent pointer sent without urg");
endmodule

`default_nettype wire

// [logic/tcp_hdr_defines.svh]
`ifndef TCP_HDR_DEFINES_SVH
`define TCP_HDR_DEFINES_SVH

// ****************************************************************
// Header layout
// ****************************************************************
`define HDR_WORDS 10
`define HDR_BYTES 16'h0014
`define DATA_OFFSET_VAL 4'h5
`define RESERVED_VAL 4'h0
`define CSUM_WORD_IDX 4'h8
`define LAST_WORD_IDX 4'h9
`define ADDEND_LAST 4'hc

// ****************************************************************
// Flag bit positions
// ****************************************************************
`define FLG_CWR 7
`define FLG_ECE 6
`define FLG_URG 5
`define FLG_ACK 4
`define FLG_PSH 3
`define FLG_RST 2
`define FLG_SYN 1
`define FLG_FIN 0

// ****************************************************************
// Reset values
// ****************************************************************
`define SEQ_RST 32'h0000_0000
`define ACK_RST 32'h0000_0000

`endif

// [logic/tcp_hdr_pkg.sv]
package tcp_hdr_pkg;

    typedef enum logic [4:0] {
        CONN_CLOSED = 5'b00001,
        CONN_LISTEN = 5'b00010,
        CONN_SYN_SENT = 5'b00100,
        CONN_SYN_RCVD = 5'b01000,
        CONN_ESTAB = 5'b10000
    } conn_state_t;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_SUM = 3'b010,
        PH_EMIT = 3'b100
    } phase_t;

endpackage

// [logic/csum_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface csum_if;
    logic load;
    logic add;
    logic [15:0] word;
    logic [15:0] sum;

    modport master (output load, output add, output word, input sum);
    modport slave (input load, input add, input word, output sum);
endinterface

`default_nettype wire

// [logic/csum_accum.sv]
`timescale 1ns/10ps
`default_nettype none

module csum_accum (
    input wire logic i_clk,
    input wire logic i_rst,
    csum_if.slave cs
);
    logic [15:0] sum_q;
    logic [15:0] sum_d;
    logic [16:0] wide;

    assign cs.sum = sum_q;

    // One's-complement add with end-around carry
    always_comb begin
        wide = {1'b0, sum_q} + {1'b0, cs.word};
        sum_d = sum_q;
        if (cs.load) begin
            sum_d = cs.word;
        end else if (cs.add) begin
            sum_d = wide[15:0] + {15'h0000, wide[16]};
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sum_q <= 16'h0000;
        end else begin
            sum_q <= sum_d;
        end
    end
endmodule

`default_nettype wire

// [tb/tcp_peer_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Remote endpoint: answers handshakes, opens on command
// ****************************************************************
module tcp_peer_model #(
    parameter logic [31:0] PSEQ = 32'h0000_0000,
    parameter logic [47:0] PMAC = 48'h0000_0000_0000,
    parameter logic [31:0] PIP = 32'h0000_0000,
    parameter logic [15:0] PPORT = 16'h0000
) (
    input wire logic i_clk,
    input wire logic [7:0] i_dly,
    input wire logic i_open,
    input wire logic i_hdr_valid,
    input wire logic [15:0] i_hdr_word,
    input wire logic i_hdr_last,
    output logic o_rx_valid,
    output logic [7:0] o_rx_flags,
    output logic [31:0] o_rx_seq,
    output logic [15:0] o_rx_len,
    output logic [47:0] o_rx_mac,
    output logic [31:0] o_rx_ip,
    output logic [15:0] o_rx_port
);
    int n = 0;
    logic [7:0] fl = 8'h00;
    logic [7:0] pend = 8'h00;
    logic [7:0] f;

    task automatic send(input logic [7:0] fg, input logic [31:0] s);
        repeat (i_dly) @(negedge i_clk);
        o_rx_valid = 1'b1;
        {o_rx_flags, o_rx_seq, o_rx_len} = {fg, s, 16'h0000};
        {o_rx_mac, o_rx_ip, o_rx_port} = {PMAC, PIP, PPORT};
        @(negedge i_clk);
        o_rx_valid = 1'b0;
        // Stale fields are scrambled so nothing reads them as valid
        {o_rx_flags, o_rx_seq, o_rx_len} = ~{o_rx_flags, o_rx_seq, o_rx_len};
        {o_rx_mac, o_rx_ip} = ~{o_rx_mac, o_rx_ip};
        o_rx_port = ~o_rx_port;
    endtask

    initial begin
        o_rx_valid = 1'b0;
        {o_rx_flags, o_rx_seq, o_rx_len, o_rx_mac, o_rx_ip, o_rx_port} = '0;
    end

    always @(posedge i_clk) begin
        if (i_hdr_valid === 1'b1) begin
            if (n == 6) fl = i_hdr_word[7:0];
            n = (i_hdr_last === 1'b1) ? 0 : n + 1;
            if (i_hdr_last === 1'b1) pend = fl;
        end
    end

    // SYN from the device gets SYN|ACK, its SYN|ACK gets ACK
    always @(negedge i_clk) begin
        if (pend[1]) begin
            f = pend;
            pend = 8'h00;
            send(f[4] ? 8'h10 : 8'h12, f[4] ? PSEQ + 1 : PSEQ);
        end
    end

    always @(posedge i_open) send(8'h02, PSEQ);
endmodule

`default_nettype wire

// [tb/tcp_header_generator_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module tcp_header_generator_tb;
    import tcp_hdr_pkg::*;
    localparam logic [31:0] PSEQ = 32'h0a1b_2c3d;
    localparam logic [47:0] PMAC = 48'h0200_0000_0007;
    localparam logic [31:0] PIP = 32'h0a00_0009;
    localparam logic [15:0] PPORT = 16'h1f90;
    localparam logic [7:0] M = 8'he8;
    logic i_clk = 0, i_rst = 1, i_start = 0, i_active_open = 0;
    logic i_passive_open = 0, i_auto_inc = 0, i_zero_csum = 0;
    logic i_frame_req = 0, i_open = 0;
    logic [7:0] i_flags_cfg = 0, dly = 1, f;
    logic [15:0] i_src_port = 0, i_dst_port = 0, i_window = 0, i_urg_ptr = 0;
    logic [15:0] i_pseudo_sum = 0, i_payload_len = 0, i_payload_sum = 0, len;
    logic [31:0] i_seq_cfg = 0, i_ack_cfg = 0, s;
    wire logic rv, o_frame_ack, o_traffic_ready, o_hdr_valid, o_hdr_last;
    wire logic [7:0] rf;
    wire logic [31:0] rs, rip, o_peer_ip;
    wire logic [15:0] rl, rp, o_hdr_word, o_peer_port;
    wire logic [47:0] rm, o_peer_mac;
    wire logic [4:0] o_conn_state;
    int fails = 0, cmp_count = 0;
    logic [159:0] hq[$], cur;

    tcp_header_generator i_tcp_header_generator (.i_clk(i_clk),
        .i_rst(i_rst), .i_start(i_start), .i_active_open(i_active_open),
        .i_passive_open(i_passive_open), .i_auto_inc(i_auto_inc),
        .i_zero_csum(i_zero_csum), .i_src_port(i_src_port),
        .i_dst_port(i_dst_port), .i_seq_cfg(i_seq_cfg), .i_ack_cfg(i_ack_cfg),
        .i_flags_cfg(i_flags_cfg), .i_window(i_window), .i_urg_ptr(i_urg_ptr),
        .i_pseudo_sum(i_pseudo_sum), .i_frame_req(i_frame_req),
        .i_payload_len(i_payload_len), .i_payload_sum(i_payload_sum),
        .i_rx_valid(rv), .i_rx_flags(rf), .i_rx_seq(rs), .i_rx_len(rl),
        .i_rx_mac(rm), .i_rx_ip(rip), .i_rx_port(rp),
        .o_frame_ack(o_frame_ack), .o_traffic_ready(o_traffic_ready),
        .o_conn_state(o_conn_state), .o_hdr_valid(o_hdr_valid),
        .o_hdr_word(o_hdr_word), .o_hdr_last(o_hdr_last),
        .o_peer_mac(o_peer_mac), .o_peer_ip(o_peer_ip),
        .o_peer_port(o_peer_port));

    tcp_peer_model #(.PSEQ(PSEQ), .PMAC(PMAC), .PIP(PIP), .PPORT(PPORT))
    i_tcp_peer_model (.i_clk(i_clk), .i_dly(dly), .i_open(i_open),
        .i_hdr_valid(o_hdr_valid), .i_hdr_word(o_hdr_word),
        .i_hdr_last(o_hdr_last), .o_rx_valid(rv), .o_rx_flags(rf),
        .o_rx_seq(rs), .o_rx_len(rl), .o_rx_mac(rm), .o_rx_ip(rip),
        .o_rx_port(rp));

    always #20 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        if (o_hdr_valid === 1'b1) begin
            cur = {cur[143:0], o_hdr_word};
            if (o_hdr_last === 1'b1) hq.push_back(cur);
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic cmp(input string nm, input logic [47:0] e,
                       input logic [47:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude;
        if (fails == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic rst;
        @(negedge i_clk);
        i_rst = 1;
        repeat (2) @(negedge i_clk);
        i_rst = 0;
        hq.delete();
    endtask

    task automatic start(input logic a, input logic p, input logic ai);
        {i_active_open, i_passive_open, i_auto_inc} = {a, p, ai};
        i_seq_cfg = $urandom;
        i_ack_cfg = $urandom;
        i_flags_cfg = f;
        i_start = 1;
        @(negedge i_clk);
        i_start = 0;
    endtask

    task automatic wait_ready;
        int k;
        k = 0;
        while (o_traffic_ready !== 1'b1 && k < 300) begin
            @(negedge i_clk);
            k++;
        end
        cmp("ready", 48'h1, {47'h0, o_traffic_ready});
    endtask

    // Model header: checksum folds pseudo, payload, length and words
    task automatic expect_hdr(input logic [31:0] sq, input logic [31:0] ak,
        input logic [7:0] fl, input logic [15:0] dp, input logic [15:0] ln,
        input logic [15:0] ps);
        logic [15:0] e[10];
        logic [31:0] sm;
        logic [159:0] got;
        int k;
        e = '{i_src_port, dp, sq[31:16], sq[15:0], fl[4] ? ak[31:16] : 16'h0,
              fl[4] ? ak[15:0] : 16'h0, {8'h50, fl}, i_window, 16'h0,
              fl[5] ? i_urg_ptr : 16'h0};
        sm = 32'(i_pseudo_sum) + 32'(ps) + 32'(ln) + 32'h14;
        for (k = 0; k < 10; k++) sm += 32'(e[k]);
        while (sm[31:16] != 0) sm = 32'(sm[15:0]) + 32'(sm[31:16]);
        e[8] = i_zero_csum ? 16'h0 : ~sm[15:0];
        k = 0;
        while (hq.size() == 0 && k < 400) begin
            @(posedge i_clk);
            k++;
        end
        cmp("hdr_seen", 48'h1, {47'h0, hq.size() != 0});
        if (hq.size() != 0) got = hq.pop_front();
        for (k = 0; k < 10; k++) begin
            cmp($sformatf("word%0d", k), 48'(e[k]),
                48'(got[159-16*k -: 16]));
        end
    endtask

    task automatic frame(input logic [7:0] fl, input logic [31:0] sq,
                         input logic [31:0] ak, input logic pv);
        int k;
        @(negedge i_clk);
        {i_src_port, i_dst_port} = $urandom;
        {i_window, i_urg_ptr} = $urandom;
        {i_pseudo_sum, i_payload_sum} = $urandom;
        i_zero_csum = 1'($urandom);
        i_payload_len = len;
        i_frame_req = 1;
        k = 0;
        while (o_frame_ack !== 1'b1 && k < 100) begin
            @(posedge i_clk);
            #1 k++;
        end
        cmp("frame_ack", 48'h1, {47'h0, o_frame_ack});
        @(negedge i_clk);
        i_frame_req = 0;
        expect_hdr(sq, ak, fl, pv ? PPORT : i_dst_port, len, i_payload_sum);
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        conclude();
    end

    initial begin
        void'($urandom(32'hae0a401b));
        repeat (2) @(negedge i_clk);
        i_rst = 0;
        cmp("state", 48'h1, 48'(o_conn_state));
        for (int m = 0; m < 3; m++) begin
            rst();
            f = (m == 0) ? 8'($urandom) | 8'h02 : 8'($urandom) & 8'hfd;
            start(0, 0, m == 2);
            wait_ready();
            s = (m == 2) ? 32'h0 : i_seq_cfg;
            for (int i = 0; i < 4; i++) begin
                len = 16'($urandom_range(1, 1500));
                frame(i == 0 ? f : f & 8'hfd, s,
                    i_ack_cfg, 0);
                s = s + ((i == 0 && f[1]) ? 32'h1 : 32'h0);
                s = s + ((m == 2) ? 32'(len) : 32'h0);
            end
        end
        rst();
        f = 8'($urandom);
        dly = 1;
        start(1, 0, 0);
        cmp("state", 48'h4, 48'(o_conn_state));
        expect_hdr(i_seq_cfg, 0, (f & M) | 8'h02,
            i_dst_port, 0, 0);
        expect_hdr(i_seq_cfg + 1, PSEQ + 1, (f & M) | 8'h10,
            i_dst_port, 0, 0);
        wait_ready();
        cmp("state", 48'h10, 48'(o_conn_state));
        s = i_seq_cfg + 1;
        for (int i = 0; i < 3; i++) begin
            len = 16'($urandom_range(1, 1500));
            frame((f & M) | 8'h10, s, PSEQ + 1, 0);
            s = s + 32'(len);
        end
        rst();
        dly = 12;
        start(0, 1, 0);
        cmp("state", 48'h2, 48'(o_conn_state));
        i_frame_req = 1;
        repeat (30) @(negedge i_clk);
        cmp("early_hdrs", 48'h0, 48'(hq.size()));
        i_frame_req = 0;
        i_open = 1;
        @(negedge i_clk);
        i_open = 0;
        expect_hdr(i_seq_cfg, PSEQ + 1, (f & M) | 8'h12,
            PPORT, 0, 0);
        wait_ready();
        cmp("peer_mac", PMAC, o_peer_mac);
        cmp("peer_ip", 48'(PIP), 48'(o_peer_ip));
        cmp("peer_port", 48'(PPORT), 48'(o_peer_port));
        len = 16'h0040;
        frame((f & M) | 8'h10, i_seq_cfg + 1, PSEQ + 1, 1);
        conclude();
    end
endmodule

`default_nettype wire
